// ### common/rsmi_cfg.svh
`ifndef RSMI_CFG_SVH
`define RSMI_CFG_SVH

// register indices; byte address is four times the index
`define RSMI_IDX_STS_A   6'h16
`define RSMI_IDX_STS_B   6'h17
`define RSMI_IDX_EN_A    6'h18
`define RSMI_IDX_EN_B    6'h19
`define RSMI_IDX_PCFG0   6'h2c
`define RSMI_IDX_PCFG1   6'h2d
`define RSMI_IDX_EN_C    6'h3a
`define RSMI_IDX_EN_D    6'h3b
`define RSMI_IDX_PDATA   6'h3c

// reset values
`define RSMI_RST_STS     8'h00
`define RSMI_RST_EN      8'h00
`define RSMI_RST_PCFG    8'h8c
`define RSMI_RST_PDATA   2'h0

// implemented-bit masks, reserved bits read zero
`define RSMI_MSK_STS_A   8'hfe
`define RSMI_MSK_B_FULL  8'hff
`define RSMI_MSK_B_NOSTR 8'haf
`define RSMI_MSK_B_RED   8'hfc
`define RSMI_MSK_EN_A    8'h9f
`define RSMI_MSK_EN_B    8'hf7
`define RSMI_MSK_PCFG    8'h8f

// field positions
`define RSMI_EN_B_PME    5
`define RSMI_EN_B_SIRQ   6
`define RSMI_EN_B_PIN    7
`define RSMI_PC_DIR      0
`define RSMI_PC_INV      1
`define RSMI_PC_FN_HI    3
`define RSMI_PC_FN_LO    2
`define RSMI_PC_OD       7

`endif

// ### common/rsmi_pkg.sv
package rsmi_pkg;

  typedef logic [7:0] rsmi_byte_t;

  typedef enum logic [1:0] {
    RSMI_FN_GPIO = 2'b00,
    RSMI_FN_RSVD = 2'b01,
    RSMI_FN_EDGE = 2'b10,
    RSMI_FN_KBD  = 2'b11
  } rsmi_fn_e;

endpackage : rsmi_pkg

// ### rtl/rsmi_top.sv
// Operation
// - status register A resets zero; bit0 reserved, bits1-7 latch the seven pin events.
// - any status bit clears when software writes one to it.
// - full variant status B maps serial3,4, gpio32,33, serial5, gpio42, serial6, gpio61.
// - full variant with strap low makes status B bits 4 and 6 reserved.
// - reduced variant reserves B bits 0,1; bits 4 and 6 both report serial5.
// - enable A resets zero; bits 0-4 and 7 enable sources, 5-6 reserved.
// - enable B resets zero; bits 0-2 and 4 enable sources, bit 3 reserved.
// - only enabled sources contribute to the group interrupt.
// - enable B bit 5 forwards group interrupt into power-management-event logic.
// - enable B bit 6 places group interrupt onto serial IRQ stream.
// - enable B bit 7 drives group interrupt onto the dedicated pin.
// - pin config bit0 direction (1 input), bit1 polarity invert, bits 6-4 reserved.
// - keyboard data pin function: 11 keyboard, 10 edge interrupt 0, 00 gpio.
// - keyboard clock pin function: 11 keyboard, 10 edge interrupt 1, 00 gpio.
// - pin config bit7 picks open drain when one, push-pull when zero.
// - both pin config registers reset to 0x8c.
`timescale 1ns/1ps
`include "rsmi_cfg.svh"

module rsmi_top
  import rsmi_pkg::*;
#(
  parameter int  ADDR_W = 8,  // apb byte address width
  parameter bit  FULL   = 1'b1 // full variant when set
) (
  input  wire logic              clk_sys_i,          // 40 MHz system clock
  input  wire logic              reset_n_i,          // async reset, standby power-on
  input  wire logic              ce_i,               // clock enable, freezes state
  input  wire logic              config_strap_option_i, // strap, caught after reset
  input  wire logic              psel_i,             // apb select
  input  wire logic              penable_i,          // apb enable
  input  wire logic              pwrite_i,           // apb direction
  input  wire logic [ADDR_W-1:0] paddr_i,            // apb byte address
  input  wire logic [31:0]       pwdata_i,           // apb write data
  output logic      [31:0]       prdata_o,           // apb read data
  output logic                   pready_o,           // apb ready
  output logic                   pslverr_o,          // apb error, unmapped
  input  wire logic [7:0]        src_en_a_i,         // levels gated by enable A
  input  wire logic [4:0]        src_en_b_i,         // levels gated by enable B
  input  wire logic [4:0]        evt_gpio_hi_i,      // gpio54..57,60 event pulses
  input  wire logic [7:0]        evt_sts_b_i,        // status B event pulses
  input  wire logic [1:0]        pin_in_i,           // kbd data/clock pin level
  output logic      [1:0]        pin_o,              // pin output value
  output logic      [1:0]        pin_oe_n_o,         // pin drive, low drives
  input  wire logic [1:0]        kbd_out_i,          // keyboard logic drive value
  output logic      [1:0]        kbd_in_o,           // pin level to keyboard logic
  output logic                   group_int_pin_n_o,  // dedicated pin, active low
  output logic                   group_to_serial_irq_o, // serial irq request
  output logic                   group_to_pm_event_o // pm event request
);

  // register file
  rsmi_byte_t sts_a_ff;
  rsmi_byte_t sts_b_ff;
  rsmi_byte_t en_a_ff;
  rsmi_byte_t en_b_ff;
  rsmi_byte_t en_c_ff;
  rsmi_byte_t en_d_ff;
  rsmi_byte_t pcfg_ff [2];
  logic [1:0] pdata_ff;
  logic       strap_ff;
  logic       strap_taken_ff;
  logic [1:0] prev_lvl_ff;

  // apb decode
  wire logic [ADDR_W-3:0] idx      = paddr_i[ADDR_W-1:2];
  wire logic              access   = psel_i & penable_i;
  wire logic              done     = access & pready_o;
  wire logic              wr       = done & pwrite_i;
  wire rsmi_byte_t        wbyte    = pwdata_i[7:0];
  wire logic              hit_sa   = idx == `RSMI_IDX_STS_A;
  wire logic              hit_sb   = idx == `RSMI_IDX_STS_B;
  wire logic              hit_ea   = idx == `RSMI_IDX_EN_A;
  wire logic              hit_eb   = idx == `RSMI_IDX_EN_B;
  wire logic              hit_ec   = idx == `RSMI_IDX_EN_C;
  wire logic              hit_ed   = idx == `RSMI_IDX_EN_D;
  wire logic              hit_p0   = idx == `RSMI_IDX_PCFG0;
  wire logic              hit_p1   = idx == `RSMI_IDX_PCFG1;
  wire logic              hit_pd   = idx == `RSMI_IDX_PDATA;
  wire logic              hit_any  = hit_sa | hit_sb | hit_ea | hit_eb | hit_ec
                                   | hit_ed | hit_p0 | hit_p1 | hit_pd;

  // status B implemented bits depend on variant and strap
  wire rsmi_byte_t msk_b = !FULL     ? `RSMI_MSK_B_RED :
                           strap_ff  ? `RSMI_MSK_B_FULL :
                                       `RSMI_MSK_B_NOSTR;

  // per-pin datapath
  logic [1:0] lvl;
  logic [1:0] edge_evt;
  logic [1:0] raw_out;
  logic [1:0] drive;
  genvar gi;
  generate
    for (gi = 0; gi < 2; gi++)
    begin : g_pin
      wire rsmi_fn_e fn  = rsmi_fn_e'(pcfg_ff[gi][`RSMI_PC_FN_HI:`RSMI_PC_FN_LO]);
      wire logic     inv = pcfg_ff[gi][`RSMI_PC_INV];
      wire logic     val = (fn == RSMI_FN_KBD) ? kbd_out_i[gi]
                                               : pdata_ff[gi];
      assign lvl[gi]      = pin_in_i[gi] ^ inv;
      assign edge_evt[gi] = (fn == RSMI_FN_EDGE) && (lvl[gi] != prev_lvl_ff[gi]);
      assign raw_out[gi]  = val ^ inv;
      // open drain only pulls low; a high is left to the pull-up
      assign drive[gi]    = !pcfg_ff[gi][`RSMI_PC_DIR]
                          && (!pcfg_ff[gi][`RSMI_PC_OD] || !raw_out[gi]);
    end
  endgenerate

  // events and clears
  wire rsmi_byte_t evt_a  = {evt_gpio_hi_i, edge_evt, 1'b0};
  wire rsmi_byte_t evt_b  = FULL ? evt_sts_b_i
                          : {evt_sts_b_i[7], evt_sts_b_i[4], evt_sts_b_i[5:2], 2'b00};
  wire rsmi_byte_t clr_a  = (wr && hit_sa) ? wbyte : 8'h00;
  wire rsmi_byte_t clr_b  = (wr && hit_sb) ? wbyte : 8'h00;
  // set wins over clear on the same edge
  wire rsmi_byte_t nxt_sts_a = ((sts_a_ff & ~clr_a) | evt_a) & `RSMI_MSK_STS_A;
  wire rsmi_byte_t nxt_sts_b = ((sts_b_ff & ~clr_b) | evt_b) & msk_b;

  // group interrupt
  wire logic grp_any = |(src_en_a_i & en_a_ff)
                     | |(src_en_b_i & en_b_ff[4:0])
                     | |(sts_a_ff & en_c_ff)
                     | |(sts_b_ff & en_d_ff);

  // read mux
  wire rsmi_byte_t rd_byte =
      hit_sa ? sts_a_ff :
      hit_sb ? sts_b_ff :
      hit_ea ? en_a_ff  :
      hit_eb ? en_b_ff  :
      hit_ec ? en_c_ff  :
      hit_ed ? en_d_ff  :
      hit_p0 ? pcfg_ff[0] :
      hit_p1 ? pcfg_ff[1] :
      hit_pd ? {4'h0, lvl, pdata_ff} : 8'h00;

  // apb answers after one wait state so read data comes from a flop
  always_ff @(posedge clk_sys_i or negedge reset_n_i)
  begin
    if (!reset_n_i)
    begin
      pready_o  <= 1'b0;
      pslverr_o <= 1'b0;
      prdata_o  <= 32'h0000_0000;
    end
    else if (ce_i)
    begin
      pready_o  <= access & ~pready_o;
      pslverr_o <= access & ~pready_o & ~hit_any;
      prdata_o  <= {24'h00_0000, rd_byte};
    end
  end

  // strap taken once after release; an async reset may not load a port value
  always_ff @(posedge clk_sys_i or negedge reset_n_i)
  begin
    if (!reset_n_i)
    begin
      strap_ff       <= 1'b0;
      strap_taken_ff <= 1'b0;
    end
    else if (ce_i && !strap_taken_ff)
    begin
      strap_ff       <= config_strap_option_i;
      strap_taken_ff <= 1'b1;
    end
  end

  always_ff @(posedge clk_sys_i or negedge reset_n_i)
  begin
    if (!reset_n_i)
    begin
      sts_a_ff <= `RSMI_RST_STS;
      sts_b_ff <= `RSMI_RST_STS;
    end
    else if (ce_i)
    begin
      sts_a_ff <= nxt_sts_a;
      sts_b_ff <= nxt_sts_b;
    end
  end

  always_ff @(posedge clk_sys_i or negedge reset_n_i)
  begin
    if (!reset_n_i)
    begin
      en_a_ff <= `RSMI_RST_EN;
      en_b_ff <= `RSMI_RST_EN;
      en_c_ff <= `RSMI_RST_EN;
      en_d_ff <= `RSMI_RST_EN;
    end
    else if (ce_i && wr)
    begin
      if (hit_ea) en_a_ff <= wbyte & `RSMI_MSK_EN_A;
      if (hit_eb) en_b_ff <= wbyte & `RSMI_MSK_EN_B;
      if (hit_ec) en_c_ff <= wbyte & `RSMI_MSK_STS_A;
      if (hit_ed) en_d_ff <= wbyte;
    end
  end

  always_ff @(posedge clk_sys_i or negedge reset_n_i)
  begin
    if (!reset_n_i)
    begin
      pcfg_ff[0] <= `RSMI_RST_PCFG;
      pcfg_ff[1] <= `RSMI_RST_PCFG;
      pdata_ff   <= `RSMI_RST_PDATA;
    end
    else if (ce_i && wr)
    begin
      if (hit_p0) pcfg_ff[0] <= wbyte & `RSMI_MSK_PCFG;
      if (hit_p1) pcfg_ff[1] <= wbyte & `RSMI_MSK_PCFG;
      if (hit_pd) pdata_ff   <= wbyte[1:0];
    end
  end

  // pins and routing; the direction bit is not forced in keyboard mode,
  // software must keep it at zero there
  always_ff @(posedge clk_sys_i or negedge reset_n_i)
  begin
    if (!reset_n_i)
    begin
      prev_lvl_ff           <= 2'h3; // idle pins rest high, no false edge
      pin_o                 <= 2'h0;
      pin_oe_n_o            <= 2'h3;
      kbd_in_o              <= 2'h3;
      group_int_pin_n_o     <= 1'b1;
      group_to_serial_irq_o <= 1'b0;
      group_to_pm_event_o   <= 1'b0;
    end
    else if (ce_i)
    begin
      prev_lvl_ff           <= lvl;
      pin_o                 <= raw_out;
      pin_oe_n_o            <= ~drive;
      kbd_in_o              <= lvl;
      group_int_pin_n_o     <= ~(grp_any & en_b_ff[`RSMI_EN_B_PIN]);
      group_to_serial_irq_o <= grp_any & en_b_ff[`RSMI_EN_B_SIRQ];
      group_to_pm_event_o   <= grp_any & en_b_ff[`RSMI_EN_B_PME];
    end
  end

  default clocking cb @(posedge clk_sys_i);
  endclocking
  default disable iff (!reset_n_i);

  a_w1c_clear: assert property (
    ce_i && wr && hit_sa |=> (sts_a_ff & $past(wbyte & ~evt_a)) == 8'h00)
    else $error("status A bit not cleared by write of one");

  a_zero_write_keep: assert property (
    ce_i && wr && hit_sb |=> (sts_b_ff & $past(sts_b_ff & ~wbyte)) == $past(sts_b_ff & ~wbyte))
    else $error("status B bit lost on write of zero");

  a_event_wins: assert property (
    ce_i && (evt_a != 8'h00) |=> (sts_a_ff & $past(evt_a)) == $past(evt_a & `RSMI_MSK_STS_A))
    else $error("status A event lost");

  a_reserved_zero: assert property (
    sts_a_ff[0] == 1'b0 && en_a_ff[6:5] == 2'b00 && en_b_ff[3] == 1'b0)
    else $error("reserved bit set");

  a_strap_rsvd: assert property (
    FULL && strap_taken_ff && !strap_ff |-> sts_b_ff[4] == 1'b0 && sts_b_ff[6] == 1'b0)
    else $error("strap-reserved status bit set");

  a_reduced_map: assert property (
    !FULL && ce_i && evt_sts_b_i[4] |=> sts_b_ff[6] && sts_b_ff[4] && sts_b_ff[1:0] == 2'b00)
    else $error("reduced variant mapping broken");

  a_pin_route: assert property (
    ce_i |=> group_int_pin_n_o == !($past(grp_any) && $past(en_b_ff[`RSMI_EN_B_PIN])))
    else $error("group pin does not follow enabled sources");

  a_sirq_route: assert property (
    ce_i ##1 ce_i |-> ##1 group_to_serial_irq_o == $past(grp_any & en_b_ff[`RSMI_EN_B_SIRQ]))
    else $error("serial irq route wrong");

  a_pme_route: assert property (
    ce_i && !en_b_ff[`RSMI_EN_B_PME] |=> !group_to_pm_event_o)
    else $error("pm event raised while disabled");

  a_gate_off: assert property (
    ce_i && !grp_any |=> group_int_pin_n_o && !group_to_serial_irq_o)
    else $error("group interrupt without enabled source");

  a_dir_input: assert property (
    ce_i && pcfg_ff[0][`RSMI_PC_DIR] |=> pin_oe_n_o[0])
    else $error("input pin driven");

  a_open_drain: assert property (
    ce_i && pcfg_ff[1][`RSMI_PC_OD] && raw_out[1] |=> pin_oe_n_o[1])
    else $error("open drain drives high");

  a_edge_latch: assert property (
    ce_i && edge_evt[0] |=> sts_a_ff[1])
    else $error("edge interrupt 0 not latched");

  a_edge_latch_b: assert property (
    ce_i && edge_evt[1] |=> sts_a_ff[2])
    else $error("edge interrupt 1 not latched");

  a_w1c_clear_b: assert property (
    ce_i && wr && hit_sb |=> (sts_b_ff & $past(wbyte & ~evt_b)) == 8'h00)
    else $error("status B bit not cleared by write of one");

  a_zero_keep_a: assert property (
    ce_i && wr && hit_sa |=> (sts_a_ff & $past(sts_a_ff & ~wbyte)) == $past(sts_a_ff & ~wbyte))
    else $error("status A bit lost on write of zero");

  a_event_wins_b: assert property (
    ce_i && (evt_b != 8'h00) |=> (sts_b_ff & $past(evt_b & msk_b)) == $past(evt_b & msk_b))
    else $error("status B event lost");

  a_status_hold: assert property (
    ce_i && !(wr && hit_sa) |=> (sts_a_ff & $past(sts_a_ff)) == $past(sts_a_ff))
    else $error("status A bit dropped without a clear");

  a_full_map: assert property (
    FULL && strap_ff && ce_i && evt_sts_b_i[6] |=> sts_b_ff[6])
    else $error("full variant status B event not latched");

  a_strap_hold: assert property (
    strap_taken_ff |=> strap_taken_ff && $stable(strap_ff))
    else $error("strap changed after capture");

  a_pcfg_rsvd: assert property (
    pcfg_ff[0][6:4] == 3'h0 && pcfg_ff[1][6:4] == 3'h0)
    else $error("pin config reserved bit set");

  a_kbd_drive: assert property (
    ce_i && pcfg_ff[0][`RSMI_PC_FN_HI:`RSMI_PC_FN_LO] == RSMI_FN_KBD
    |=> pin_o[0] == $past(kbd_out_i[0] ^ pcfg_ff[0][`RSMI_PC_INV]))
    else $error("keyboard data value not on pin");

  a_gpio_drive: assert property (
    ce_i && pcfg_ff[0] == 8'h00 |=> !pin_oe_n_o[0] && pin_o[0] == $past(pdata_ff[0]))
    else $error("gpio output value not driven");

  a_push_pull: assert property (
    ce_i && !pcfg_ff[0][`RSMI_PC_OD] && !pcfg_ff[0][`RSMI_PC_DIR] |=> !pin_oe_n_o[0])
    else $error("push-pull output not driven");

  a_pme_follow: assert property (
    ce_i && grp_any && en_b_ff[`RSMI_EN_B_PME] |=> group_to_pm_event_o)
    else $error("pm event not raised");

  a_pin_off: assert property (
    ce_i && !en_b_ff[`RSMI_EN_B_PIN] |=> group_int_pin_n_o)
    else $error("group pin asserted while not routed");

  a_sirq_off: assert property (
    ce_i && !en_b_ff[`RSMI_EN_B_SIRQ] |=> !group_to_serial_irq_o)
    else $error("serial irq raised while not routed");

  a_edge_quiet: assert property (
    ce_i && !sts_a_ff[1] && pcfg_ff[0][`RSMI_PC_FN_HI:`RSMI_PC_FN_LO] != RSMI_FN_EDGE
    |=> !sts_a_ff[1])
    else $error("status bit 1 set outside edge function");

  a_group_on: assert property (
    ce_i && |(sts_a_ff & en_c_ff) && en_b_ff[`RSMI_EN_B_PIN] |=> !group_int_pin_n_o)
    else $error("enabled status bit not on group pin");

  a_en_gate: assert property (
    ce_i && |(src_en_a_i & en_a_ff) && en_b_ff[`RSMI_EN_B_SIRQ] |=> group_to_serial_irq_o)
    else $error("enabled source not on serial irq");

  a_sts_a_map: assert property (
    ce_i && evt_gpio_hi_i[4] |=> sts_a_ff[7])
    else $error("gpio event not latched in bit 7");

  c_clear_race: cover property (ce_i && wr && hit_sa && |(wbyte & evt_a));
  c_pin_fire:   cover property (group_int_pin_n_o ##1 !group_int_pin_n_o);
  c_edge_mode:  cover property (ce_i && edge_evt[1]);
  c_unmapped:   cover property (pslverr_o && pready_o);
  c_strap_low:  cover property (strap_taken_ff && !strap_ff);

endmodule : rsmi_top

// ### test/rsmi_host_model.sv
`timescale 1ns/1ps
// host side sees the three routed group requests; registered, one cycle late
module rsmi_host_model (
  input  wire logic       clk_sys_i, // system clock
  input  wire logic       reset_n_i, // async reset
  input  wire logic       pin_n_i,   // dedicated pin, active low
  input  wire logic       sirq_i,    // serial irq request
  input  wire logic       pme_i,     // pm event request
  output logic      [2:0] seen_o     // pme, sirq, pin seen
);
  always_ff @(posedge clk_sys_i or negedge reset_n_i)
  begin
    if (!reset_n_i)
      seen_o <= 3'h0;
    else
      seen_o <= {pme_i, sirq_i, ~pin_n_i};
  end
endmodule : rsmi_host_model

// ### test/rsmi_top_tb_top.sv
`timescale 1ns/1ps
module rsmi_top_tb_top;
  import rsmi_pkg::*;
  logic        clk_sys_i = 1'b0;
  logic        reset_n_i = 1'b0;
  logic        psel      = 1'b0;
  logic        pen       = 1'b0;
  logic        pwr       = 1'b0;
  logic [7:0]  padr      = 8'h00;
  logic [31:0] pwd       = 32'h0;
  logic [31:0] prd;
  logic        rdy;
  logic        err;
  logic [7:0]  src_a     = 8'h00;
  logic [4:0]  evt_a     = 5'h00;
  logic [7:0]  evt_b     = 8'h00;
  logic [1:0]  ext_pin   = 2'h3;
  logic [1:0]  pin_o;
  logic [1:0]  oe_n;
  logic        gpin_n;
  logic        gsirq;
  logic        gpme;
  logic [2:0]  seen;
  logic [31:0] d;
  logic [31:0] dr;
  logic [31:0] prd_r;
  logic        e;
  logic        strap     = 1'b1;
  logic [4:0]  src_b     = 5'h00;
  logic [1:0]  kin;
  int          fails     = 0;
  int          num_checks = 0;
  // pulled-up wire: device drives only while its enable is low
  wire  [1:0]  pin_lvl   = (oe_n & ext_pin) | (~oe_n & pin_o);

  rsmi_top dut_u (.clk_sys_i(clk_sys_i), .reset_n_i(reset_n_i), .ce_i(1'b1),
    .config_strap_option_i(strap), .psel_i(psel), .penable_i(pen), .pwrite_i(pwr),
    .paddr_i(padr), .pwdata_i(pwd), .prdata_o(prd), .pready_o(rdy), .pslverr_o(err),
    .src_en_a_i(src_a), .src_en_b_i(src_b), .evt_gpio_hi_i(evt_a), .evt_sts_b_i(evt_b),
    .pin_in_i(pin_lvl), .pin_o(pin_o), .pin_oe_n_o(oe_n), .kbd_out_i(2'h3),
    .kbd_in_o(kin), .group_int_pin_n_o(gpin_n), .group_to_serial_irq_o(gsirq),
    .group_to_pm_event_o(gpme));
  // reduced variant shares the bus; only its read data is looked at
  rsmi_top #(.FULL(1'b0)) dut_red_u (.clk_sys_i(clk_sys_i), .reset_n_i(reset_n_i),
    .ce_i(1'b1), .config_strap_option_i(strap), .psel_i(psel), .penable_i(pen),
    .pwrite_i(pwr), .paddr_i(padr), .pwdata_i(pwd), .prdata_o(prd_r), .pready_o(),
    .pslverr_o(), .src_en_a_i(src_a), .src_en_b_i(src_b), .evt_gpio_hi_i(evt_a),
    .evt_sts_b_i(evt_b), .pin_in_i(pin_lvl), .pin_o(), .pin_oe_n_o(), .kbd_out_i(2'h3),
    .kbd_in_o(), .group_int_pin_n_o(), .group_to_serial_irq_o(),
    .group_to_pm_event_o());
  rsmi_host_model host_u (.clk_sys_i(clk_sys_i), .reset_n_i(reset_n_i),
    .pin_n_i(gpin_n), .sirq_i(gsirq), .pme_i(gpme), .seen_o(seen));

  always #12.5 clk_sys_i = ~clk_sys_i;

  task automatic wrap_up;
    $display("checks %0d mismatches %0d", num_checks, fails);
    if (fails == 0 && num_checks > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask : wrap_up

  task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
    num_checks++;
    if (got !== exp)
    begin
      fails++;
      $display("FAIL %s expected %h seen %h", nm, exp, got);
    end
  endtask : chk

  // one apb transfer; entered just after a rising edge
  task automatic apb(input logic w, input logic [5:0] idx, input logic [7:0] wd);
    int n;
    psel <= 1'b1;
    pwr  <= w;
    padr <= {idx, 2'b00};
    pwd  <= {24'h0, wd};
    @(posedge clk_sys_i);
    pen  <= 1'b1;
    n = 0;
    do
    begin
      @(posedge clk_sys_i);
      n++;
    end while (rdy !== 1'b1 && n < 20);
    d = prd;
    dr = prd_r;
    e = err;
    psel <= 1'b0;
    pen  <= 1'b0;
    if (rdy !== 1'b1)
    begin
      fails++;
      wrap_up();
    end
    @(posedge clk_sys_i);
  endtask : apb

  task automatic rchk(input logic [5:0] idx, input logic [7:0] exp);
    apb(1'b0, idx, 8'h00);
    chk($sformatf("reg %h", idx), {24'h0, exp}, d);
  endtask : rchk

  task automatic outs(input string nm, input logic [2:0] exp);
    repeat (3) @(posedge clk_sys_i);
    chk(nm, {29'h0, exp}, {29'h0, gpme, gsirq, ~gpin_n});
    chk("host seen", {29'h0, exp}, {29'h0, seen});
  endtask : outs

  logic [5:0] ix [6] = '{6'h16, 6'h17, 6'h18, 6'h19, 6'h2c, 6'h2d};
  logic [7:0] rv [6] = '{8'h00, 8'h00, 8'h00, 8'h00, 8'h8c, 8'h8c};
  logic [7:0] mk [6] = '{8'h00, 8'h00, 8'h9f, 8'hf7, 8'h8f, 8'h8f};

  initial
  begin
    repeat (4) @(posedge clk_sys_i);
    reset_n_i <= 1'b1;
    @(posedge clk_sys_i);
    for (int i = 0; i < 6; i++)
      rchk(ix[i], rv[i]);
    apb(1'b0, 6'h20, 8'h00);
    chk("unmapped err", 32'h1, {31'h0, e});
    $display("test reset values done");
    for (int i = 2; i < 6; i++)
    begin
      apb(1'b1, ix[i], 8'hff);
      rchk(ix[i], mk[i]);
      apb(1'b1, ix[i], rv[i]);
    end
    $display("test reserved bits done");
    evt_a <= 5'h1f;
    evt_b <= 8'hff;
    @(posedge clk_sys_i);
    evt_a <= 5'h00;
    evt_b <= 8'h00;
    @(posedge clk_sys_i);
    rchk(6'h16, 8'hf8);
    rchk(6'h17, 8'hff);
    chk("reduced sts b", 32'hfc, dr);
    apb(1'b1, 6'h16, 8'h08);
    rchk(6'h16, 8'hf0);
    apb(1'b1, 6'h16, 8'h00);
    rchk(6'h16, 8'hf0);
    apb(1'b1, 6'h16, 8'hff);
    apb(1'b1, 6'h17, 8'hff);
    rchk(6'h16, 8'h00);
    rchk(6'h17, 8'h00);
    $display("test status clear done");
    src_a <= 8'h01;
    apb(1'b1, 6'h19, 8'he0);
    outs("group masked", 3'b000);
    apb(1'b1, 6'h18, 8'h01);
    outs("group all", 3'b111);
    apb(1'b1, 6'h19, 8'h20);
    outs("group pme", 3'b100);
    apb(1'b1, 6'h19, 8'h40);
    outs("group sirq", 3'b010);
    apb(1'b1, 6'h19, 8'h80);
    outs("group pin", 3'b001);
    src_a <= 8'h00;
    evt_a <= 5'h01;
    @(posedge clk_sys_i);
    evt_a <= 5'h00;
    apb(1'b1, 6'h3a, 8'h08);
    outs("group status", 3'b001);
    apb(1'b1, 6'h16, 8'hff);
    outs("group cleared", 3'b000);
    apb(1'b1, 6'h19, 8'h81);
    src_b <= 5'h01;
    outs("group src b", 3'b001);
    src_b <= 5'h00;
    $display("test routing done");
    apb(1'b1, 6'h2c, 8'h00);
    apb(1'b1, 6'h3c, 8'h01);
    repeat (2) @(posedge clk_sys_i);
    chk("push pull", 32'h1, {30'h0, oe_n[0], pin_o[0]});
    apb(1'b1, 6'h2c, 8'h02);
    repeat (2) @(posedge clk_sys_i);
    chk("inverted", 32'h0, {30'h0, oe_n[0], pin_o[0]});
    apb(1'b1, 6'h2c, 8'h80);
    repeat (2) @(posedge clk_sys_i);
    chk("open drain off", 32'h1, {31'h0, oe_n[0]});
    for (int p = 0; p < 2; p++)
    begin
      apb(1'b1, ix[4 + p], 8'h09);
      repeat (2) @(posedge clk_sys_i);
      chk("kbd in idle", 32'h1, {31'h0, kin[p]});
      ext_pin[p] <= 1'b0;
      repeat (3) @(posedge clk_sys_i);
      chk("kbd in low", 32'h0, {31'h0, kin[p]});
      rchk(6'h16, 8'h02 << p);
      apb(1'b1, 6'h16, 8'hff);
    end
    $display("test pins done");
    strap     <= 1'b0;
    reset_n_i <= 1'b0;
    repeat (2) @(posedge clk_sys_i);
    reset_n_i <= 1'b1;
    @(posedge clk_sys_i);
    evt_b <= 8'hff;
    @(posedge clk_sys_i);
    evt_b <= 8'h00;
    rchk(6'h17, 8'haf);
    rchk(6'h2c, 8'h8c);
    outs("reset outs", 3'b000);
    $display("test strap reset done");
    wrap_up();
  end
endmodule : rsmi_top_tb_top
